// >>> inc/win_decode_pkg.sv
// Constants, field layout and carrier types of the internal-to-PCI window decoder.
// Assumes a 64-bit register port with byte addresses and a 36-bit internal bus address.
//
// Operation
// - Window base registers hold internal-bus address bits 35:8, so bases sit on 256-byte steps.
// - Base bit 37 disables byte swapping for the window when set and enables it when clear.
// - The swap-disable bit resets to 1 in little endian mode and to 0 in big endian mode.
// - Base bit 36 applies endian transfer to accesses through the window when set.
// - The endian-transfer bit resets to 0 in little endian mode and to 1 in big endian mode.
// - In big endian mode a set swap-disable bit leaves 32-bit access byte order as swapped.
// - The memory space 2 base resets to zero, or to 0x0_1FC0_00 when booting from PCI.
// - The I/O window base has the same swap, transfer and base fields, its base resetting to 0.
// - Mask registers hold a mask for address bits 35:8 in bits 31:4 and reset to zero.
// - The memory space 2 mask resets to zero, or to 0x0_03FF_FF when booting from PCI.
// - Each window has a PCI base, bits 39:8, that supplies the PCI address of its cycles.
package win_decode_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 64;

  localparam logic [ADDR_W-1:0] OFF_MEM2_GBASE = 16'hd130;
  localparam logic [ADDR_W-1:0] OFF_IO_GBASE   = 16'hd138;
  localparam logic [ADDR_W-1:0] OFF_MEM0_MASK  = 16'hd140;
  localparam logic [ADDR_W-1:0] OFF_MEM1_MASK  = 16'hd144;
  localparam logic [ADDR_W-1:0] OFF_MEM2_MASK  = 16'hd148;
  localparam logic [ADDR_W-1:0] OFF_MEM2_PBASE = 16'hd160;
  localparam logic [ADDR_W-1:0] OFF_IO_PBASE   = 16'hd168;

  localparam int SWAP_BIT  = 37;
  localparam int XFER_BIT  = 36;
  localparam int BASE_MSB  = 35;
  localparam int BASE_LSB  = 8;
  localparam int MASK_MSB  = 31;
  localparam int MASK_LSB  = 4;
  localparam int PBASE_MSB = 39;
  localparam int FIELD_W   = BASE_MSB - BASE_LSB + 1;
  localparam int PFIELD_W  = PBASE_MSB - BASE_LSB + 1;

  localparam logic [FIELD_W-1:0]  BASE_RST      = 28'h000_0000;
  localparam logic [FIELD_W-1:0]  MEM2_BOOT_RST = 28'h01F_C000;
  localparam logic [FIELD_W-1:0]  MASK_RST      = 28'h000_0000;
  localparam logic [FIELD_W-1:0]  MEM2_BOOT_MSK = 28'h003_FFFF;
  localparam logic [PFIELD_W-1:0] PBASE_RST     = 32'h0000_0000;

  typedef struct packed {
    logic [BASE_MSB:0] addr;
    logic              dword;
    logic [31:0]       data;
  } acc_req_t;

  typedef struct packed {
    logic               hitMem2;
    logic               hitIo;
    logic [PBASE_MSB:0] pciAddr;
    logic               swap;
    logic               endianXfer;
    logic [31:0]        data;
  } acc_rsp_t;

  typedef struct packed {
    logic               swapDisable;
    logic               endianXfer;
    logic [FIELD_W-1:0] base;
  } win_ctl_t;

endpackage : win_decode_pkg

// >>> hw/pci_initiator_window_decode.sv
// Register file and address decode for memory space 2 and I/O windows of the
// internal-to-PCI initiator path, plus the mask registers of memory spaces 0..2.
// Assumes strap pins stable for at least three clocks before resetn is released,
// and an I/O mask supplied by the neighbouring register block.
`timescale 1ns/100ps
module pci_initiator_window_decode
  import win_decode_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              strapBigEndian,
  input  wire logic              strapPciBoot,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              accValid,
  input  wire acc_req_t          accReq,
  input  wire logic [FIELD_W-1:0] ioMask,
  output logic                   rspValid,
  output acc_rsp_t               rsp,
  output logic     [FIELD_W-1:0] mem0Mask,
  output logic     [FIELD_W-1:0] mem1Mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; stage one feeds stage two only
  logic [1:0] bigSync_r;
  logic [1:0] bootSync_r;
  wire logic  bigEndian = bigSync_r[1];
  wire logic  pciBoot   = bootSync_r[1];

  always_ff @(posedge ref_clk) begin
    bigSync_r  <= {bigSync_r[0], strapBigEndian};
    bootSync_r <= {bootSync_r[0], strapPciBoot};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  win_ctl_t            mem2Ctl_r;
  win_ctl_t            ioCtl_r;
  logic [FIELD_W-1:0]  mem0Mask_r;
  logic [FIELD_W-1:0]  mem1Mask_r;
  logic [FIELD_W-1:0]  mem2Mask_r;
  logic [PFIELD_W-1:0] mem2Pbase_r;
  logic [PFIELD_W-1:0] ioPbase_r;
  logic [DATA_W-1:0]   regRdata_r;

  wire logic selMem2G = regAddr == OFF_MEM2_GBASE;
  wire logic selIoG   = regAddr == OFF_IO_GBASE;
  wire logic selM0    = regAddr == OFF_MEM0_MASK;
  wire logic selM1    = regAddr == OFF_MEM1_MASK;
  wire logic selM2    = regAddr == OFF_MEM2_MASK;
  wire logic selM2P   = regAddr == OFF_MEM2_PBASE;
  wire logic selIoP   = regAddr == OFF_IO_PBASE;

  // Write data split into fields; reserved bits never reach storage
  wire win_ctl_t wrCtl = '{swapDisable: regWdata[SWAP_BIT],
                           endianXfer:  regWdata[XFER_BIT],
                           base:        regWdata[BASE_MSB:BASE_LSB]};
  wire logic [FIELD_W-1:0]  wrMask  = regWdata[MASK_MSB:MASK_LSB];
  wire logic [PFIELD_W-1:0] wrPbase = regWdata[PBASE_MSB:BASE_LSB];

  // Endian-mode and boot-mode dependent reset values
  wire win_ctl_t mem2Rst = '{swapDisable: ~bigEndian,
                             endianXfer:  bigEndian,
                             base: pciBoot ? MEM2_BOOT_RST : BASE_RST};
  wire win_ctl_t ioRst   = '{swapDisable: ~bigEndian,
                             endianXfer:  bigEndian,
                             base:        BASE_RST};
  wire logic [FIELD_W-1:0] mem2MaskRst = pciBoot ? MEM2_BOOT_MSK : MASK_RST;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mem2Ctl_r   <= mem2Rst;
      ioCtl_r     <= ioRst;
      mem0Mask_r  <= MASK_RST;
      mem1Mask_r  <= MASK_RST;
      mem2Mask_r  <= mem2MaskRst;
      mem2Pbase_r <= PBASE_RST;
      ioPbase_r   <= PBASE_RST;
    end else if (regWr) begin
      if (selMem2G) mem2Ctl_r   <= wrCtl;
      if (selIoG)   ioCtl_r     <= wrCtl;
      if (selM0)    mem0Mask_r  <= wrMask;
      if (selM1)    mem1Mask_r  <= wrMask;
      if (selM2)    mem2Mask_r  <= wrMask;
      if (selM2P)   mem2Pbase_r <= wrPbase;
      if (selIoP)   ioPbase_r   <= wrPbase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one cycle latency, unmapped and reserved bits read zero
  function automatic logic [DATA_W-1:0] ctlWord(input win_ctl_t c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[SWAP_BIT] = c.swapDisable;
    w[XFER_BIT] = c.endianXfer;
    w[BASE_MSB:BASE_LSB] = c.base;
    return w;
  endfunction : ctlWord

  function automatic logic [DATA_W-1:0] maskWord(input logic [FIELD_W-1:0] m);
    logic [DATA_W-1:0] w;
    w = '0;
    w[MASK_MSB:MASK_LSB] = m;
    return w;
  endfunction : maskWord

  function automatic logic [DATA_W-1:0] pbaseWord(input logic [PFIELD_W-1:0] p);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PBASE_MSB:BASE_LSB] = p;
    return w;
  endfunction : pbaseWord

  wire logic [DATA_W-1:0] rdMux =
      selMem2G ? ctlWord(mem2Ctl_r)      :
      selIoG   ? ctlWord(ioCtl_r)        :
      selM0    ? maskWord(mem0Mask_r)    :
      selM1    ? maskWord(mem1Mask_r)    :
      selM2    ? maskWord(mem2Mask_r)    :
      selM2P   ? pbaseWord(mem2Pbase_r)  :
      selIoP   ? pbaseWord(ioPbase_r)    : '0;

  always_ff @(posedge ref_clk) begin
    if (!resetn) regRdata_r <= '0;
    else         regRdata_r <= regRd ? rdMux : '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window match and translation
  function automatic logic winHit(input logic [FIELD_W-1:0] a,
                                  input logic [FIELD_W-1:0] b,
                                  input logic [FIELD_W-1:0] m);
    return ((a ^ b) & ~m) == '0;
  endfunction : winHit

  // Masked bits are window offset and pass through; the rest come from the PCI base
  function automatic logic [PBASE_MSB:0] xlate(input logic [BASE_MSB:0] a,
                                               input logic [PFIELD_W-1:0] p,
                                               input logic [FIELD_W-1:0] m);
    logic [PFIELD_W-1:0] mw;
    logic [PFIELD_W-1:0] aw;
    mw = {{(PFIELD_W-FIELD_W){1'b0}}, m};
    aw = {{(PFIELD_W-FIELD_W){1'b0}}, a[BASE_MSB:BASE_LSB]};
    return {(p & ~mw) | (aw & mw), a[BASE_LSB-1:0]};
  endfunction : xlate

  wire logic [FIELD_W-1:0] accField = accReq.addr[BASE_MSB:BASE_LSB];
  wire logic hitMem2 = winHit(accField, mem2Ctl_r.base, mem2Mask_r);
  wire logic hitIo   = winHit(accField, ioCtl_r.base, ioMask);

  // Memory space 2 wins when both windows claim the address
  wire win_ctl_t selCtl = hitMem2 ? mem2Ctl_r : ioCtl_r;
  wire logic [PBASE_MSB:0] selPci = hitMem2 ?
      xlate(accReq.addr, mem2Pbase_r, mem2Mask_r) :
      xlate(accReq.addr, ioPbase_r, ioMask);

  // Big endian dword accesses stay swapped even with swapping disabled
  wire logic doSwap = ~selCtl.swapDisable | (bigEndian & accReq.dword);
  wire logic [31:0] swapData = {accReq.data[7:0], accReq.data[15:8],
                                accReq.data[23:16], accReq.data[31:24]};

  wire acc_rsp_t rspNxt = '{hitMem2:    hitMem2,
                            hitIo:      hitIo & ~hitMem2,
                            pciAddr:    (hitMem2 | hitIo) ? selPci : '0,
                            swap:       doSwap,
                            endianXfer: selCtl.endianXfer,
                            data:       doSwap ? swapData : accReq.data};

  acc_rsp_t rsp_r;
  logic     rspValid_r;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rspValid_r <= 1'b0;
      rsp_r      <= '0;
    end else begin
      rspValid_r <= accValid;
      if (accValid) rsp_r <= rspNxt;
    end
  end

  assign regRdata = regRdata_r;
  assign rspValid = rspValid_r;
  assign rsp      = rsp_r;
  assign mem0Mask = mem0Mask_r;
  assign mem1Mask = mem1Mask_r;

endmodule : pci_initiator_window_decode

// >>> tb/win_decode_assertions.sv
// Port checker of the window decoder, bound to its top module.
// Assumes one ref_clk domain with synchronous active-low resetn.
`timescale 1ns/100ps
module win_decode_checker
  import win_decode_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire logic [ADDR_W-1:0]  regAddr,
  input wire logic [DATA_W-1:0]  regWdata,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [DATA_W-1:0]  regRdata,
  input wire logic               accValid,
  input wire acc_req_t           accReq,
  input wire logic               rspValid,
  input wire acc_rsp_t           rsp,
  input wire logic [FIELD_W-1:0] mem0Mask,
  input wire logic [FIELD_W-1:0] mem1Mask
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  acc_req_t lastReq_r;
  always_ff @(posedge ref_clk) lastReq_r <= accReq;
  wire logic [31:0] revData = {<<8{lastReq_r.data}};
  wire logic        anyHit  = rsp.hitMem2 | rsp.hitIo;
  sequence wr_m2_s; regWr && regAddr == OFF_MEM2_MASK; endsequence
  sequence rd_m2_s; regRd && regAddr == OFF_MEM2_MASK; endsequence
  rd_idle_a: assert property (!regRd |=> regRdata == '0)
    else $error("read data not idle");
  mask_readback_a: assert property (wr_m2_s ##1 rd_m2_s |=>
    regRdata == ($past(regWdata, 2) & 64'h0000_0000_FFFF_FFF0)) else $error("mask readback");
  mask_write_a: assert property (regWr && regAddr == OFF_MEM0_MASK |=>
    mem0Mask == FIELD_W'($past(regWdata) >> 4)) else $error("mask write lost");
  mask_hold_a: assert property (!regWr |=> $stable(mem0Mask) && $stable(mem1Mask))
    else $error("mask moved");
  rsp_follow_a: assert property (accValid |=> rspValid) else $error("no response");
  rsp_hold_a: assert property (!accValid |=> !rspValid && $stable(rsp))
    else $error("response not held");
  miss_zero_a: assert property (rspValid && !anyHit |-> rsp.pciAddr == '0)
    else $error("miss address");
  low_addr_a: assert property (rspValid && anyHit |->
    rsp.pciAddr[7:0] == lastReq_r.addr[7:0]) else $error("low address bits");
  data_order_a: assert property (rspValid |->
    rsp.data == (rsp.swap ? revData : lastReq_r.data)) else $error("byte order");
  hit_single_a: assert property (rspValid |-> !(rsp.hitMem2 && rsp.hitIo))
    else $error("double hit");
endmodule : win_decode_checker
bind pci_initiator_window_decode win_decode_checker win_decode_checker_inst (.*);

// >>> tb/acc_master.sv
// Internal bus master model issuing single accesses toward the windows.
// Assumes each call starts right after a rising edge of ref_clk.
`timescale 1ns/100ps
module acc_master
  import win_decode_pkg::*;
(
  input  wire logic     ref_clk,
  output logic          accValid,
  output acc_req_t      accReq,
  input  wire logic     rspValid,
  input  wire acc_rsp_t rsp
);
  initial begin
    accValid = 1'b0;
    accReq   = '0;
  end
  task automatic issue(input acc_req_t q, output logic [4:0] f, output acc_rsp_t r);
    accValid <= 1'b1;
    accReq   <= q;
    @(posedge ref_clk);
    accValid <= 1'b0;
    // Released lines flip so a stale request never looks valid
    accReq   <= ~q;
    @(negedge ref_clk);
    f = {rspValid, rsp.hitMem2, rsp.hitIo, rsp.swap, rsp.endianXfer};
    r = rsp;
    @(posedge ref_clk);
  endtask : issue
endmodule : acc_master

// >>> tb/pci_initiator_window_decode_bench.sv
// Bench of the window decoder: register tasks plus accesses through the master model.
// Assumes package, design, checker and master model compiled before it.
`timescale 1ns/100ps
module pci_initiator_window_decode_bench;
  import win_decode_pkg::*;
  logic               ref_clk, resetn, strapBigEndian, strapPciBoot, regWr, regRd;
  logic               accValid, rspValid;
  logic [ADDR_W-1:0]  regAddr;
  logic [DATA_W-1:0]  regWdata, regRdata;
  logic [FIELD_W-1:0] ioMask, mem0Mask, mem1Mask;
  acc_req_t           accReq;
  acc_rsp_t           rsp;
  int                 badCount, checkCount;
  pci_initiator_window_decode pci_initiator_window_decode_inst (.ref_clk, .resetn,
    .strapBigEndian, .strapPciBoot, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .accValid, .accReq, .ioMask, .rspValid, .rsp, .mem0Mask, .mem1Mask);
  acc_master acc_master_inst (.ref_clk, .accValid, .accReq, .rspValid, .rsp);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Strobe stays up; the next rd or acc call lowers it so writes may run back to back
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    regWr   <= 1'b0;
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    check(regRdata, e);
    @(posedge ref_clk);
  endtask : rd
  task automatic acc(input acc_req_t q, input logic [4:0] f, input logic [39:0] p,
                     input logic [31:0] d);
    logic [4:0] fs;
    acc_rsp_t   r;
    regWr <= 1'b0;
    acc_master_inst.issue(q, fs, r);
    check(64'(fs), 64'(f));
    check(64'(r.pciAddr), 64'(p));
    check(64'(r.data), 64'(d));
  endtask : acc
  // Straps change inside reset, well before release
  task automatic restart(input logic big, input logic boot);
    resetn         <= 1'b0;
    strapBigEndian <= big;
    strapPciBoot   <= boot;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
  endtask : restart
  task automatic results;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    badCount++;
    results();
  end
  initial begin
    {resetn, strapBigEndian, strapPciBoot, regWr, regRd, regAddr, regWdata} = '0;
    ioMask = 28'h000_00FF;
    @(posedge ref_clk);
    restart(1'b0, 1'b0);
    rd(OFF_MEM2_GBASE, 64'h0000_0020_0000_0000);
    rd(OFF_IO_GBASE, 64'h0000_0020_0000_0000);
    rd(OFF_MEM2_MASK, 64'h0);
    wr(OFF_MEM0_MASK, '1);
    rd(OFF_MEM0_MASK, 64'h0000_0000_FFFF_FFF0);
    check(64'(mem0Mask), 64'h0000_0000_0FFF_FFFF);
    wr(OFF_MEM1_MASK, 64'h0000_0000_00FF_FFF0);
    rd(16'hd178, 64'h0);
    check(64'(mem1Mask), 64'h0000_0000_000F_FFFF);
    wr(OFF_MEM2_GBASE, '1);
    rd(OFF_MEM2_GBASE, 64'h0000_003F_FFFF_FF00);
    wr(OFF_MEM2_GBASE, 64'h0000_0020_1000_0000);
    wr(OFF_MEM2_MASK, 64'h0000_0000_0003_FFF0);
    rd(OFF_MEM2_MASK, 64'h0000_0000_0003_FFF0);
    wr(OFF_MEM2_PBASE, 64'h0000_0080_0000_0000);
    acc('{36'h0_1012_3456, 1'b1, 32'h1122_3344}, 5'b11000, 40'h80_0012_3456, 32'h1122_3344);
    acc('{36'h0_2000_0000, 1'b0, 32'h1122_3344}, 5'b10000, 40'h0, 32'h1122_3344);
    acc('{36'h0_0000_1234, 1'b0, 32'h1122_3344}, 5'b10100, 40'h1234, 32'h1122_3344);
    wr(OFF_MEM2_GBASE, 64'h0000_0010_1000_0000);
    acc('{36'h0_1012_3456, 1'b0, 32'h1122_3344}, 5'b11011, 40'h80_0012_3456, 32'h4433_2211);
    // Both windows claim this address; memory space 2 must win
    wr(OFF_MEM2_GBASE, 64'h0000_0010_0000_0000);
    acc('{36'h0_0000_1234, 1'b0, 32'h1122_3344}, 5'b11011, 40'h80_0000_1234, 32'h4433_2211);
    restart(1'b1, 1'b1);
    rd(OFF_MEM2_GBASE, 64'h0000_0010_1FC0_0000);
    rd(OFF_IO_GBASE, 64'h0000_0010_0000_0000);
    rd(OFF_MEM2_MASK, 64'h0000_0000_003F_FFF0);
    rd(OFF_MEM0_MASK, 64'h0);
    wr(OFF_MEM2_GBASE, 64'h0000_0030_1FC0_0000);
    acc('{36'h0_1FC0_0010, 1'b1, 32'h1122_3344}, 5'b11011, 40'h03C0_0010, 32'h4433_2211);
    acc('{36'h0_1FC0_0010, 1'b0, 32'h1122_3344}, 5'b11001, 40'h03C0_0010, 32'h1122_3344);
    results();
  end
endmodule : pci_initiator_window_decode_bench
